/* File: logic/dma_seq_pkg.sv */
// Purpose: shared constants and state codes for the dual address cycle sequencer
// Assumes: 32-bit AHB-Lite register bus, one channel
// Notes: offsets are byte addresses
package dma_seq_pkg;
  // register byte offsets
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] count_off = 8'h04;
  localparam logic [7:0] block_off = 8'h08;
  localparam logic [7:0] status_off = 8'h0c;
  // control register field positions
  localparam int cte_bit = 0;
  localparam int mte_bit = 1;
  localparam int end_interrupt_enable_bit = 2;
  localparam int ext_sel_bit = 3;
  localparam int edge_bit = 4;
  localparam int mode_lsb = 5;
  localparam int repeat_bit = 7;
  localparam int transfer_end_strobe_en_bit = 8;
  // status register field positions
  localparam int done_bit = 0;
  localparam int pending_bit = 1;
  localparam int state_lsb = 8;
  localparam int count_lsb = 16;
  // transfer modes
  localparam logic [1:0] mode_short = 2'h0;
  localparam logic [1:0] mode_steal = 2'h1;
  localparam logic [1:0] mode_burst = 2'h2;
  localparam logic [1:0] mode_block = 2'h3;
  // reset values
  localparam logic [15:0] count_rst = 16'h0001;
  localparam logic [7:0] block_rst = 8'h01;
  // widths
  localparam int count_w = 16;
  localparam int block_w = 8;
  // sequencer states
  typedef enum logic [5:0] {
    s_idle = 6'h01,
    s_req = 6'h02,
    s_read = 6'h04,
    s_write = 6'h08,
    s_dead = 6'h10,
    s_rel = 6'h20
  } seq_state_e;
endpackage : dma_seq_pkg

/* File: logic/xfer_counter.sv */
// Purpose: loadable down counter for transfer and block counts
// Assumes: load has priority over decrement
// Notes: a loaded zero means full range, decrement wraps
`timescale 1ns/1ns
module xfer_counter #(
  parameter int width = 16
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic load,
  input wire logic [width-1:0] load_value,
  input wire logic dec,
  // state
  output logic [width-1:0] count,
  output logic is_one
);
  logic [width-1:0] count_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= '0;
    end else if (load) begin
      count_q <= load_value;
    end else if (dec) begin
      count_q <= count_q - {{(width-1){1'b0}}, 1'b1};
    end
  end

  assign count = count_q;
  assign is_one = (count_q == {{(width-1){1'b0}}, 1'b1});
endmodule : xfer_counter

/* File: logic/req_acceptor.sv */
// Purpose: external request pin acceptance, edge or level activated
// Assumes: pin is asynchronous and active low
// Notes: acceptance closes on activation and reopens on the reopen pulse, in edge mode only once the pin has been seen high
`timescale 1ns/1ns
module req_acceptor (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // pin and configuration
  input wire logic external_request_pin_n,
  input wire logic edge_mode,
  input wire logic enabled,
  // sequencer handshake
  input wire logic consume,
  input wire logic reopen,
  output logic pending
);
  logic sync1_q, sync2_q;
  logic pending_q, accept_q, waiting_q, high_seen_q;

  // the first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= external_request_pin_n;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      high_seen_q <= 1'b0;
    end else if (!enabled || consume) begin
      high_seen_q <= 1'b0;
    end else if (sync2_q) begin
      high_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      accept_q <= 1'b0;
      waiting_q <= 1'b0;
    end else if (!enabled) begin
      accept_q <= 1'b1;
      waiting_q <= 1'b0;
    end else if (consume) begin
      accept_q <= 1'b0;
      waiting_q <= 1'b0;
    end else if ((reopen || waiting_q) && (!edge_mode || high_seen_q || sync2_q)) begin
      accept_q <= 1'b1;
      waiting_q <= 1'b0;
    end else if (reopen) begin
      waiting_q <= 1'b1;
    end
  end

  // sampling runs every cycle once enabled is registered, so from the edge after the write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pending_q <= 1'b0;
    end else if (!enabled || consume) begin
      pending_q <= 1'b0;
    end else if (accept_q && !sync2_q && (!edge_mode || high_seen_q)) begin
      pending_q <= 1'b1;
    end
  end

  assign pending = pending_q;
endmodule : req_acceptor

/* File: logic/dual_address_dma_cycle_sequencer.sv */
// Purpose: bus cycle sequencer for one dual address channel with AHB-Lite registers
// Assumes: bus controller grants the bus and flags the end of each read and write cycle
// Notes: one channel only, so no priority arbitration lives here
`timescale 1ns/1ns
module dual_address_dma_cycle_sequencer (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // bus controller
  input wire logic bus_grant,
  input wire logic cycle_done,
  output logic bus_request,
  output logic dma_read_cycle,
  output logic dma_write_cycle,
  output logic dma_dead_cycle,
  // interrupt controller
  input wire logic nmi,
  output logic end_request,
  // external device
  input wire logic external_request_pin_n,
  output logic transfer_end_strobe_n
);
  dma_seq_pkg::seq_state_e state_q, state_d;
  logic cte_q, mte_q, end_interrupt_enable_q, ext_sel_q, edge_q, repeat_q, transfer_end_strobe_en_q;
  logic [1:0] mode_q;
  logic done_q, bus_req_q, transfer_end_strobe_n_q, end_req_q, hreadyout_q;
  logic [31:0] hrdata_q;
  logic wr_q;
  logic [7:0] waddr_q;
  logic [15:0] reload_q;
  logic [7:0] block_size_q;
  logic wr_ctrl, wr_count, wr_block, wr_status, rd_req;
  logic go, consume, wr_end, last_xfer, blk_end, final_end, reopen, pending;
  logic cnt_load, cnt_dec, blk_load, blk_dec, cnt_is_one, blk_is_one;
  logic [15:0] cnt_val, cnt_load_val;
  logic [7:0] blk_load_val;
  logic is_block, is_burst;

  // ahb address phase and decode; the slave never inserts wait states
  assign rd_req = hsel && hready && htrans[1] && !hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      waddr_q <= 8'h00;
    end else begin
      wr_q <= hsel && hready && htrans[1] && hwrite && (hsize == 3'h2);
      waddr_q <= haddr;
    end
  end

  assign wr_ctrl = wr_q && (waddr_q == dma_seq_pkg::ctrl_off);
  assign wr_count = wr_q && (waddr_q == dma_seq_pkg::count_off);
  assign wr_block = wr_q && (waddr_q == dma_seq_pkg::block_off);
  assign wr_status = wr_q && (waddr_q == dma_seq_pkg::status_off);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hrdata_q <= 32'h0000_0000;
      if (rd_req) begin
        case (haddr)
          dma_seq_pkg::ctrl_off: begin
            hrdata_q[dma_seq_pkg::cte_bit] <= cte_q;
            hrdata_q[dma_seq_pkg::mte_bit] <= mte_q;
            hrdata_q[dma_seq_pkg::end_interrupt_enable_bit] <= end_interrupt_enable_q;
            hrdata_q[dma_seq_pkg::ext_sel_bit] <= ext_sel_q;
            hrdata_q[dma_seq_pkg::edge_bit] <= edge_q;
            hrdata_q[dma_seq_pkg::mode_lsb +: 2] <= mode_q;
            hrdata_q[dma_seq_pkg::repeat_bit] <= repeat_q;
            hrdata_q[dma_seq_pkg::transfer_end_strobe_en_bit] <= transfer_end_strobe_en_q;
          end
          dma_seq_pkg::count_off: begin
            hrdata_q[15:0] <= reload_q;
          end
          dma_seq_pkg::block_off: begin
            hrdata_q[7:0] <= block_size_q;
          end
          dma_seq_pkg::status_off: begin
            hrdata_q[dma_seq_pkg::done_bit] <= done_q;
            hrdata_q[dma_seq_pkg::pending_bit] <= pending;
            hrdata_q[dma_seq_pkg::state_lsb +: 6] <= state_q;
            hrdata_q[dma_seq_pkg::count_lsb +: 16] <= cnt_val;
          end
          default: begin
            hrdata_q <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // control register; a software write lands after the hardware end clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cte_q <= 1'b0;
      end_interrupt_enable_q <= 1'b0;
      ext_sel_q <= 1'b0;
      edge_q <= 1'b0;
      mode_q <= dma_seq_pkg::mode_short;
      repeat_q <= 1'b0;
      transfer_end_strobe_en_q <= 1'b0;
    end else begin
      if (final_end && !repeat_q) begin
        cte_q <= 1'b0;
      end
      if (wr_ctrl) begin
        cte_q <= hwdata[dma_seq_pkg::cte_bit];
        end_interrupt_enable_q <= hwdata[dma_seq_pkg::end_interrupt_enable_bit];
        ext_sel_q <= hwdata[dma_seq_pkg::ext_sel_bit];
        edge_q <= hwdata[dma_seq_pkg::edge_bit];
        mode_q <= hwdata[dma_seq_pkg::mode_lsb +: 2];
        repeat_q <= hwdata[dma_seq_pkg::repeat_bit];
        transfer_end_strobe_en_q <= hwdata[dma_seq_pkg::transfer_end_strobe_en_bit];
      end
    end
  end

  // nmi in burst mode with cte set wins over a software set in the same cycle: suspension must not be undone
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mte_q <= 1'b0;
    end else if (nmi && cte_q && is_burst) begin
      mte_q <= 1'b0;
    end else if (wr_ctrl) begin
      mte_q <= hwdata[dma_seq_pkg::mte_bit];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reload_q <= dma_seq_pkg::count_rst;
      block_size_q <= dma_seq_pkg::block_rst;
    end else begin
      if (wr_count) begin
        reload_q <= hwdata[15:0];
      end
      if (wr_block) begin
        block_size_q <= hwdata[7:0];
      end
    end
  end

  // end flag: hardware set wins over the write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= 1'b0;
    end else if (final_end) begin
      done_q <= 1'b1;
    end else if (wr_status && hwdata[dma_seq_pkg::done_bit]) begin
      done_q <= 1'b0;
    end
  end

  assign is_block = (mode_q == dma_seq_pkg::mode_block);
  assign is_burst = (mode_q == dma_seq_pkg::mode_burst);
  assign wr_end = (state_q == dma_seq_pkg::s_write) && cycle_done;
  assign blk_end = is_block && blk_is_one;
  assign last_xfer = is_block ? (cnt_is_one && blk_is_one) : cnt_is_one;
  assign final_end = wr_end && last_xfer;
  assign go = cte_q && mte_q && (ext_sel_q ? pending : 1'b1);
  assign consume = (state_q == dma_seq_pkg::s_idle) && go && ext_sel_q;
  assign reopen = is_block ? (state_q == dma_seq_pkg::s_dead) : wr_end;

  assign cnt_load = wr_count || (final_end && repeat_q);
  assign cnt_load_val = wr_count ? hwdata[15:0] : reload_q;
  assign cnt_dec = wr_end && (!is_block || blk_is_one);
  assign blk_load = wr_block || (wr_end && blk_end);
  assign blk_load_val = wr_block ? hwdata[7:0] : block_size_q;
  assign blk_dec = wr_end && is_block;

  xfer_counter #(.width(dma_seq_pkg::count_w)) u_count (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(cnt_load),
    .load_value(cnt_load_val),
    .dec(cnt_dec),
    .count(cnt_val),
    .is_one(cnt_is_one)
  );

  xfer_counter #(.width(dma_seq_pkg::block_w)) u_block (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(blk_load),
    .load_value(blk_load_val),
    .dec(blk_dec),
    .count(),
    .is_one(blk_is_one)
  );

  req_acceptor u_req (
    .hclk(hclk),
    .hresetn(hresetn),
    .external_request_pin_n(external_request_pin_n),
    .edge_mode(edge_q),
    .enabled(cte_q && mte_q && ext_sel_q),
    .consume(consume),
    .reopen(reopen),
    .pending(pending)
  );

  // sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      dma_seq_pkg::s_idle: begin
        if (go) begin
          state_d = dma_seq_pkg::s_req;
        end
      end
      dma_seq_pkg::s_req: begin
        if (bus_grant) begin
          state_d = dma_seq_pkg::s_read;
        end
      end
      dma_seq_pkg::s_read: begin
        if (cycle_done) begin
          state_d = dma_seq_pkg::s_write;
        end
      end
      dma_seq_pkg::s_write: begin
        if (cycle_done) begin
          if (last_xfer || blk_end) begin
            state_d = dma_seq_pkg::s_dead;
          end else if (is_block) begin
            state_d = dma_seq_pkg::s_read;
          end else if (is_burst && mte_q && !nmi) begin
            state_d = dma_seq_pkg::s_read;
          end else begin
            state_d = dma_seq_pkg::s_rel;
          end
        end
      end
      dma_seq_pkg::s_dead: begin
        state_d = dma_seq_pkg::s_rel;
      end
      dma_seq_pkg::s_rel: begin
        state_d = dma_seq_pkg::s_idle;
      end
      default: begin
        state_d = dma_seq_pkg::s_idle;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= dma_seq_pkg::s_idle;
    end else begin
      state_q <= state_d;
    end
  end

  // bus held from grant through the dead state; dropped for at least the release state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_req_q <= 1'b0;
    end else begin
      bus_req_q <= (state_d != dma_seq_pkg::s_idle) && (state_d != dma_seq_pkg::s_rel);
    end
  end

  // end strobe low across the final write; short mode shows it only when repeating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      transfer_end_strobe_n_q <= 1'b1;
    end else begin
      transfer_end_strobe_n_q <= !(transfer_end_strobe_en_q && ((mode_q != dma_seq_pkg::mode_short) || repeat_q)
                   && (state_d == dma_seq_pkg::s_write) && last_xfer);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      end_req_q <= 1'b0;
    end else begin
      end_req_q <= final_end && end_interrupt_enable_q;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign bus_request = bus_req_q;
  assign dma_read_cycle = state_q[2];
  assign dma_write_cycle = state_q[3];
  assign dma_dead_cycle = state_q[4];
  assign end_request = end_req_q;
  assign transfer_end_strobe_n = transfer_end_strobe_n_q;

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence dead_then_release;
    (state_q == dma_seq_pkg::s_dead) ##1 (state_q == dma_seq_pkg::s_rel) ##1 !bus_req_q;
  endsequence

  AST_DEAD_AFTER_FINAL: assert property (final_end |=> dead_then_release)
    else $error("final write not followed by one dead state");
  AST_BLOCK_DEAD: assert property (wr_end && blk_end |=> dma_dead_cycle ##1 !dma_dead_cycle)
    else $error("block end without single dead state");
  AST_SHORT_RELEASE: assert property (wr_end && !last_xfer && (mode_q == dma_seq_pkg::mode_short)
    |=> (state_q == dma_seq_pkg::s_rel) ##1 !bus_req_q)
    else $error("short mode kept the bus");
  AST_STEAL_RELEASE: assert property (wr_end && !last_xfer && (mode_q == dma_seq_pkg::mode_steal)
    |=> !bus_req_q)
    else $error("cycle steal kept the bus");
  AST_BURST_HOLD: assert property (wr_end && is_burst && !last_xfer && mte_q && !nmi
    |=> dma_read_cycle && bus_req_q)
    else $error("burst released early");
  AST_NMI_CLEAR: assert property (nmi && cte_q && is_burst |=> !mte_q)
    else $error("nmi did not clear master enable");
  AST_NMI_SUSPEND: assert property (wr_end && is_burst && !last_xfer && (nmi || !mte_q) |=> !bus_req_q)
    else $error("burst not suspended after nmi");
  AST_BLOCK_NMI: assert property (wr_end && is_block && !blk_is_one |=> dma_read_cycle)
    else $error("block interrupted");
  AST_PAIR: assert property (dma_read_cycle && cycle_done |=> dma_write_cycle && bus_req_q)
    else $error("read and write split");
  AST_TRANSFER_END_STROBE_LOW: assert property ($rose(dma_write_cycle) && last_xfer && transfer_end_strobe_en_q && repeat_q
    |-> !transfer_end_strobe_n)
    else $error("end strobe not low in final cycle");
  AST_TRANSFER_END_STROBE_HIGH: assert property (!dma_write_cycle |-> transfer_end_strobe_n)
    else $error("end strobe low outside final write");
  AST_END_CLEAR: assert property (final_end && !repeat_q && !wr_ctrl |=> !cte_q ##1 !bus_req_q)
    else $error("enable not cleared at count end");
endmodule : dual_address_dma_cycle_sequencer

/* File: verif/dma_bus_partner.sv */
// Purpose: bus controller stand-in that grants the bus and ends each dma read or write cycle
// Assumes: pace 0..3 sets the wait cycles before a grant and before each cycle end
// Notes: grant drops one cycle after the request, as a real arbiter lags behind
`timescale 1ns/1ns
module dma_bus_partner (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // sequencer side
  input wire logic bus_request,
  input wire logic dma_read_cycle,
  input wire logic dma_write_cycle,
  // pacing from the bench
  input wire logic [1:0] pace,
  output logic bus_grant,
  output logic cycle_done
);
  logic [1:0] gcnt_q;
  logic [1:0] wcnt_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_grant <= 1'b0;
      gcnt_q <= 2'h0;
    end else if (!bus_request) begin
      bus_grant <= 1'b0;
      gcnt_q <= 2'h0;
    end else if (!bus_grant) begin
      if (gcnt_q >= pace) bus_grant <= 1'b1;
      else gcnt_q <= gcnt_q + 2'h1;
    end
  end

  // one end pulse per cycle; the pulse clears itself so a read never ends twice
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cycle_done <= 1'b0;
      wcnt_q <= 2'h0;
    end else if (cycle_done || !(dma_read_cycle || dma_write_cycle)) begin
      cycle_done <= 1'b0;
      wcnt_q <= 2'h0;
    end else if (wcnt_q >= pace) begin
      cycle_done <= 1'b1;
    end else begin
      wcnt_q <= wcnt_q + 2'h1;
    end
  end
endmodule : dma_bus_partner

/* File: verif/dual_address_dma_cycle_sequencer_tb_top.sv */
// Purpose: self-checking bench for the dual address cycle sequencer
// Assumes: one bus controller stand-in, request pin driven by the bench
// Notes: each write end pops a note {strobe, next step, end pulse}; next step 0 read, 1 release, 2 dead
`timescale 1ns/1ns
module dual_address_dma_cycle_sequencer_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic bus_grant;
  logic cycle_done;
  logic bus_request;
  logic dma_read_cycle;
  logic dma_write_cycle;
  logic dma_dead_cycle;
  logic nmi = 1'b0;
  logic end_request;
  logic pin_n = 1'b1;
  logic transfer_end_strobe_n;
  logic [7:0] rnd_q = 8'h44;
  logic rd_dp = 1'b0;
  logic [31:0] rd_q[$];
  logic [3:0] wr_q[$];
  logic [3:0] n;
  logic nx_v = 1'b0;
  logic [1:0] nx_q;
  logic nx_end;
  int wr_seen = 0;
  int exp_wr = 0;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;

  always #5 hclk = ~hclk;

  dual_address_dma_cycle_sequencer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .bus_grant(bus_grant), .cycle_done(cycle_done),
    .bus_request(bus_request), .dma_read_cycle(dma_read_cycle), .dma_write_cycle(dma_write_cycle),
    .dma_dead_cycle(dma_dead_cycle), .nmi(nmi), .end_request(end_request),
    .external_request_pin_n(pin_n), .transfer_end_strobe_n(transfer_end_strobe_n));

  dma_bus_partner bus_u (.hclk(hclk), .hresetn(hresetn), .bus_request(bus_request),
    .dma_read_cycle(dma_read_cycle), .dma_write_cycle(dma_write_cycle), .pace(rnd_q[1:0]),
    .bus_grant(bus_grant), .cycle_done(cycle_done));

  function automatic logic [7:0] lfsr8(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr8

  // random pacing keeps grant and cycle lengths varied
  always @(posedge hclk) rnd_q <= lfsr8(rnd_q);

  task automatic end_sim;
    if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic [7:0] a, input logic w, input logic [2:0] sz, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= !w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_dp <= 1'b0;
    hsel <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    bus(a, 1'b0, 3'h2, 32'h0);
  endtask : rd

  task automatic note(input logic s, input logic [1:0] nx, input logic e);
    wr_q.push_back({s, nx, e});
    exp_wr++;
  endtask : note

  task automatic wait_wr(input int k);
    while (wr_seen < k) @(posedge hclk);
  endtask : wait_wr

  task automatic settle;
    repeat (30) @(posedge hclk);
    chk(wr_q.size(), 0);
  endtask : settle

  task automatic nmi_in_read;
    while (dma_read_cycle !== 1'b1) @(posedge hclk);
    nmi <= 1'b1;
    @(posedge hclk);
    nmi <= 1'b0;
  endtask : nmi_in_read

  task automatic pulse_pin;
    pin_n <= 1'b0;
    repeat (4) @(posedge hclk);
    pin_n <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask : pulse_pin

  always @(posedge hclk) begin
    if (hresetn) begin
      if (rd_dp) chk(hrdata, rd_q.size() ? rd_q.pop_front() : 32'hdead0000);
      if (rd_dp) chk(hresp, 1'b0);
      if (nx_v) begin
        if (nx_q == 2'd0) chk(dma_read_cycle, 1'b1);
        else if (nx_q == 2'd1) chk(bus_request, 1'b0);
        else chk(dma_dead_cycle, 1'b1);
        chk(end_request, nx_end);
        nx_v = 1'b0;
      end
      if (dma_write_cycle && cycle_done) begin
        wr_seen++;
        n = wr_q.size() ? wr_q.pop_front() : 4'hf;
        chk(wr_q.size() < 32'hffff && n !== 4'hf, 1'b1);
        chk(transfer_end_strobe_n, n[3]);
        nx_q = n[2:1];
        nx_end = n[0];
        nx_v = 1'b1;
      end
      if (!dma_write_cycle) chk(transfer_end_strobe_n, 1'b1);
      if (dma_read_cycle || dma_write_cycle) chk(bus_request, 1'b1);
    end
  end

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, refused writes and an unmapped place
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h1);
    rd(8'h08, 32'h1);
    rd(8'h0c, 32'h100);
    bus(8'h00, 1'b1, 3'h0, 32'h3);
    bus(8'h10, 1'b1, 3'h2, 32'hffff);
    rd(8'h00, 32'h0);
    rd(8'h10, 32'h0);
    // cycle steal, auto start, end interrupt and strobe enabled
    note(1'b1, 2'd1, 1'b0);
    note(1'b1, 2'd1, 1'b0);
    note(1'b0, 2'd2, 1'b1);
    bus(8'h04, 1'b1, 3'h2, 32'h3);
    bus(8'h00, 1'b1, 3'h2, 32'h127);
    wait_wr(exp_wr);
    settle();
    rd(8'h00, 32'h126);
    rd(8'h0c, 32'h101);
    bus(8'h0c, 1'b1, 3'h2, 32'h1);
    // burst keeps the bus to the end
    note(1'b1, 2'd0, 1'b0);
    note(1'b1, 2'd0, 1'b0);
    note(1'b1, 2'd0, 1'b0);
    note(1'b0, 2'd2, 1'b0);
    bus(8'h04, 1'b1, 3'h2, 32'h4);
    bus(8'h00, 1'b1, 3'h2, 32'h143);
    wait_wr(exp_wr);
    settle();
    // nmi mid burst: current unit ends, bus released, master enable cleared
    note(1'b1, 2'd0, 1'b0);
    note(1'b1, 2'd0, 1'b0);
    note(1'b1, 2'd1, 1'b0);
    bus(8'h04, 1'b1, 3'h2, 32'h8);
    bus(8'h00, 1'b1, 3'h2, 32'h143);
    wait_wr(exp_wr - 1);
    nmi_in_read();
    wait_wr(exp_wr);
    settle();
    rd(8'h00, 32'h141);
    bus(8'h00, 1'b1, 3'h2, 32'h0);
    // nmi during the last unit still lets it finish
    note(1'b0, 2'd2, 1'b0);
    bus(8'h04, 1'b1, 3'h2, 32'h1);
    bus(8'h00, 1'b1, 3'h2, 32'h143);
    nmi_in_read();
    wait_wr(exp_wr);
    settle();
    rd(8'h00, 32'h140);
    // block mode, pin low level, nmi inside a block is ignored
    note(1'b1, 2'd0, 1'b0);
    note(1'b1, 2'd2, 1'b0);
    note(1'b1, 2'd0, 1'b0);
    note(1'b0, 2'd2, 1'b0);
    bus(8'h04, 1'b1, 3'h2, 32'h2);
    bus(8'h08, 1'b1, 3'h2, 32'h2);
    bus(8'h00, 1'b1, 3'h2, 32'h16b);
    pin_n <= 1'b0;
    wait_wr(exp_wr - 3);
    nmi_in_read();
    wait_wr(exp_wr);
    pin_n <= 1'b1;
    settle();
    rd(8'h00, 32'h16a);
    // falling edge, steal: a held low pin gives one unit only
    note(1'b1, 2'd1, 1'b0);
    note(1'b1, 2'd2, 1'b0);
    bus(8'h04, 1'b1, 3'h2, 32'h2);
    bus(8'h00, 1'b1, 3'h2, 32'h3b);
    pin_n <= 1'b0;
    wait_wr(exp_wr - 1);
    repeat (40) @(posedge hclk);
    chk(wr_q.size(), 1);
    pin_n <= 1'b1;
    repeat (4) @(posedge hclk);
    pin_n <= 1'b0;
    wait_wr(exp_wr);
    pin_n <= 1'b1;
    settle();
    // level steal: a held low pin runs unit after unit
    note(1'b1, 2'd1, 1'b0);
    note(1'b1, 2'd2, 1'b0);
    bus(8'h04, 1'b1, 3'h2, 32'h2);
    bus(8'h00, 1'b1, 3'h2, 32'h2b);
    pin_n <= 1'b0;
    wait_wr(exp_wr);
    pin_n <= 1'b1;
    settle();
    // edge block: one pulse moves one whole block
    note(1'b1, 2'd0, 1'b0);
    note(1'b1, 2'd2, 1'b0);
    bus(8'h04, 1'b1, 3'h2, 32'h1);
    bus(8'h08, 1'b1, 3'h2, 32'h2);
    bus(8'h00, 1'b1, 3'h2, 32'h7b);
    pulse_pin();
    wait_wr(exp_wr);
    settle();
    // short repeat, edge pulses: strobe on the count end, enable kept
    note(1'b1, 2'd1, 1'b0);
    note(1'b0, 2'd2, 1'b0);
    bus(8'h04, 1'b1, 3'h2, 32'h2);
    bus(8'h00, 1'b1, 3'h2, 32'h19b);
    pulse_pin();
    wait_wr(exp_wr - 1);
    pulse_pin();
    wait_wr(exp_wr);
    settle();
    rd(8'h00, 32'h19b);
    bus(8'h00, 1'b1, 3'h2, 32'h0);
    repeat (4) @(posedge hclk);
    chk(rd_q.size(), 0);
    end_sim();
  end
endmodule : dual_address_dma_cycle_sequencer_tb_top
